/* File: design/port_zero_pkg.sv */
// constants for the eight-pin port zero control block
// assumes a byte-wide register port with printed offsets as addresses
package port_zero_pkg;

	localparam int PIN_COUNT = 8;
	localparam int ADDR_W = 8;

	// register offsets
	localparam logic [7:0] DATA_OFFSET = 8'h80;
	localparam logic [7:0] DRIVE_OFFSET = 8'h91;
	localparam logic [7:0] LCD_BIAS_OFFSET = 8'h92;
	localparam logic [7:0] ANALOG_OFFSET = 8'hAF;
	localparam logic [7:0] LED_CTRL_OFFSET = 8'hB1;
	localparam logic [7:0] PIN_STATE_OFFSET = 8'hB2;

	// reset values
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [7:0] DRIVE_RESET = 8'h00;
	localparam logic [7:0] LCD_BIAS_RESET = 8'h00;
	localparam logic [2:0] ANALOG_RESET = 3'h0;
	localparam logic [7:0] LED_CTRL_RESET = 8'h04;

	// field positions
	localparam int ANALOG_LSB = 5;
	localparam int LED_DUTY_LSB = 6;
	localparam int LED_COMMON_PINS = 4;

	// led duty selections
	typedef enum logic [1:0] {
		LED_OFF = 2'h0,
		LED_DUTY_8 = 2'h1,
		LED_DUTY_9 = 2'h2,
		LED_DUTY_10 = 2'h3
	} led_duty_t;

	// owner of each pin
	typedef enum logic [3:0] {
		OWN_GPIO = 4'h1,
		OWN_ANALOG = 4'h2,
		OWN_LCD = 4'h4,
		OWN_LED = 4'h8
	} pin_owner_t;

endpackage : port_zero_pkg

/* File: design/pin_input_sync.sv */
// two-stage synchroniser for the port input pins
// assumes pins are asynchronous to clk_i
`timescale 1ns/100ps
module pin_input_sync
	import port_zero_pkg::*;
#(
	parameter int WIDTH = 8
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_reg;

	// first stage feeds only the second
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta_reg <= '0;
			sync_o <= '0;
		end
		else
		begin
			meta_reg <= async_i;
			sync_o <= meta_reg;
		end
	end

endmodule : pin_input_sync

/* File: design/port_pin_mux.sv */
// one pin's function selection and pad control
// assumes the pad resolves drive, pull-up and bias from these levels
`timescale 1ns/100ps
module port_pin_mux
	import port_zero_pkg::*;
(
	input wire logic data_i,
	input wire logic drive_en_i,
	input wire logic lcd_bias_i,
	input wire logic analog_en_i,
	input wire logic led_en_i,
	input wire logic led_level_i,
	input wire logic lcd_level_i,
	output logic pad_o,
	output logic pad_oe_o,
	output logic pull_up_o,
	output logic schmitt_en_o,
	output logic analog_sel_o,
	output logic lcd_sel_o,
	output pin_owner_t owner_o
);

	// owner priority: led scan, lcd bias, analog, then plain gpio
	always_comb
	begin
		pad_o = 1'b0;
		pad_oe_o = 1'b0;
		pull_up_o = 1'b0;
		schmitt_en_o = 1'b0;
		analog_sel_o = 1'b0;
		lcd_sel_o = 1'b0;
		owner_o = OWN_GPIO;
		if (led_en_i)
		begin
			owner_o = OWN_LED;
			pad_o = led_level_i;
			pad_oe_o = 1'b1;
		end
		else if (lcd_bias_i)
		begin
			owner_o = OWN_LCD;
			lcd_sel_o = 1'b1;
			pad_o = lcd_level_i;
		end
		else if (analog_en_i)
		begin
			owner_o = OWN_ANALOG;
			analog_sel_o = 1'b1;
		end
		else if (drive_en_i)
		begin
			pad_o = data_i;
			pad_oe_o = 1'b1;
		end
		else
		begin
			pull_up_o = data_i;
			schmitt_en_o = 1'b1;
		end
	end

endmodule : port_pin_mux

/* File: design/port_zero_pin_control.sv */
// port zero pin control: registers and per-pin function selection
// assumes a single-cycle register port and external pad, scanner, lcd
// and adc logic that consume the per-pin selects
//
// Function
// - drive off, data one gives pull-up; data zero gives high impedance.
// - drive enable one makes push-pull output; zero makes Schmitt input.
// - lcd bias bit forces half-bias drive regardless of data or drive.
// - analog field routes pins seven, six, five to adc channels.
// - lcd bias and analog enables win over drive enable.
// - led duty field selects scan; enabled scan takes commons zero to three.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
module port_zero_pin_control
	import port_zero_pkg::*;
#(
	parameter int PINS = PIN_COUNT
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic [PINS-1:0] pad_i,
	input wire logic [LED_COMMON_PINS-1:0] led_common_level_i,
	input wire logic [PINS-1:0] lcd_common_level_i,
	output logic [PINS-1:0] pad_o,
	output logic [PINS-1:0] pad_oe_o,
	output logic [PINS-1:0] pull_up_o,
	output logic [PINS-1:0] schmitt_en_o,
	output logic [PINS-1:0] lcd_common_out_o,
	output logic [2:0] analog_channel_pin_o,
	output logic [1:0] led_duty_select_o,
	output logic [7:0] led_scan_control_o,
	output logic [PINS-1:0] pin_in_o
);

	logic [7:0] port_zero_data_reg;
	logic [7:0] port_zero_drive_enable_reg;
	logic [7:0] lcd_bias_enable_reg;
	logic [2:0] analog_input_enable_reg;
	logic [7:0] led_scan_control_reg;
	logic [7:0] rdata_next;
	logic [PINS-1:0] pin_sync;
	logic [PINS-1:0] analog_pin;
	logic [PINS-1:0] led_pin;
	logic [PINS-1:0] schmitt_en;
	logic led_active;

	// data register, read back as the latch value
	// cleared data at reset
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			port_zero_data_reg <= DATA_RESET;
		else if (wr_i && addr_i == DATA_OFFSET)
			port_zero_data_reg <= wdata_i;
	end

	// drive enable register
	// drive off at reset
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			port_zero_drive_enable_reg <= DRIVE_RESET;
		else if (wr_i && addr_i == DRIVE_OFFSET)
			port_zero_drive_enable_reg <= wdata_i;
	end

	// lcd bias enable register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			lcd_bias_enable_reg <= LCD_BIAS_RESET;
		else if (wr_i && addr_i == LCD_BIAS_OFFSET)
			lcd_bias_enable_reg <= wdata_i;
	end

	// analog enable lives in the top three bits; low bits reserved
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			analog_input_enable_reg <= ANALOG_RESET;
		else if (wr_i && addr_i == ANALOG_OFFSET)
			analog_input_enable_reg <= wdata_i[7:ANALOG_LSB];
	end

	// led control; only the duty field is used here, rest passes out
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			led_scan_control_reg <= LED_CTRL_RESET;
		else if (wr_i && addr_i == LED_CTRL_OFFSET)
			led_scan_control_reg <= wdata_i;
	end

	// read mux; unmapped addresses read zero
	always_comb
	begin
		rdata_next = 8'h00;
		case (addr_i)
			DATA_OFFSET: rdata_next = port_zero_data_reg;
			DRIVE_OFFSET: rdata_next = port_zero_drive_enable_reg;
			LCD_BIAS_OFFSET: rdata_next = lcd_bias_enable_reg;
			ANALOG_OFFSET: rdata_next = {analog_input_enable_reg, 5'h00};
			LED_CTRL_OFFSET: rdata_next = led_scan_control_reg;
			PIN_STATE_OFFSET: rdata_next = pin_sync & schmitt_en;
			default: rdata_next = 8'h00;
		endcase
	end

	// read data holds only in the cycle after the strobe
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rdata_o <= 8'h00;
		else if (rd_i)
			rdata_o <= rdata_next;
		else
			rdata_o <= 8'h00;
	end

	// pins are asynchronous, so two flops before any use
	pin_input_sync #(
		.WIDTH(PINS)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i(pad_i),
		.sync_o(pin_sync)
	);

	assign led_active = led_scan_control_reg[7:LED_DUTY_LSB] != LED_OFF;
	assign led_duty_select_o = led_scan_control_reg[7:LED_DUTY_LSB];
	assign led_scan_control_o = led_scan_control_reg;

	// pins five to seven map to analog bits
	assign analog_pin = {analog_input_enable_reg, 5'h00};
	assign analog_channel_pin_o = analog_input_enable_reg;
	assign led_pin = led_active ? {4'h0, 4'hF} : 8'h00;

	// per-pin priority lives in the mux
	genvar g;
	generate
		for (g = 0; g < PINS; g++)
		begin : g_pin
			port_pin_mux u_mux (
				.data_i(port_zero_data_reg[g]),
				.drive_en_i(port_zero_drive_enable_reg[g]),
				.lcd_bias_i(lcd_bias_enable_reg[g]),
				.analog_en_i(analog_pin[g]),
				.led_en_i(led_pin[g]),
				.led_level_i(g < LED_COMMON_PINS ?
					led_common_level_i[g % LED_COMMON_PINS] : 1'b0),
				.lcd_level_i(lcd_common_level_i[g]),
				.pad_o(pad_o[g]),
				.pad_oe_o(pad_oe_o[g]),
				.pull_up_o(pull_up_o[g]),
				.schmitt_en_o(schmitt_en[g]),
				.analog_sel_o(),
				.lcd_sel_o(lcd_common_out_o[g]),
				.owner_o()
			);
		end
	endgenerate

	assign schmitt_en_o = schmitt_en;
	// digital input reads zero where the pin is not an input
	assign pin_in_o = pin_sync & schmitt_en;

endmodule : port_zero_pin_control

/* File: testbench/port_zero_chk.sv */
// checker: port relations of the port zero pin control block
// assumes it is bound to the block and sees only its ports
`timescale 1ns/100ps
module port_zero_chk
	import port_zero_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic [3:0] led_common_level_i,
	input wire logic [7:0] pad_o,
	input wire logic [7:0] pad_oe_o,
	input wire logic [7:0] pull_up_o,
	input wire logic [7:0] schmitt_en_o,
	input wire logic [7:0] lcd_common_out_o,
	input wire logic [2:0] analog_channel_pin_o,
	input wire logic [1:0] led_duty_select_o,
	input wire logic [7:0] led_scan_control_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// all pins idle right after reset
	reset_idle_a: assert property ($fell(rst_i) |-> pad_oe_o == 8'h00 &&
		pull_up_o == 8'h00 && schmitt_en_o == 8'hFF)
		else $error("pins not idle after reset");
	pull_drive_excl_a: assert property ((pull_up_o & pad_oe_o) == 8'h00)
		else $error("pull-up on a driven pin");
	drive_output_a: assert property (wr_i && addr_i == DRIVE_OFFSET &&
		lcd_common_out_o == 8'h00 && analog_channel_pin_o == 3'h0 &&
		led_duty_select_o == 2'h0 |=> pad_oe_o == $past(wdata_i))
		else $error("drive enable not applied");
	input_off_a: assert property ((schmitt_en_o & pad_oe_o) == 8'h00)
		else $error("driven pin left as input");
	lcd_takes_pin_a: assert property (wr_i && addr_i == LCD_BIAS_OFFSET
		|=> lcd_common_out_o[7:4] == $past(wdata_i[7:4]))
		else $error("lcd bias select wrong");
	lcd_wins_a: assert property ((pad_oe_o & lcd_common_out_o) == 8'h00)
		else $error("lcd pin also driven");
	analog_field_a: assert property (wr_i && addr_i == ANALOG_OFFSET
		|=> analog_channel_pin_o == $past(wdata_i[7:5]))
		else $error("analog field wrong");
	analog_wins_a: assert property ((pad_oe_o[7:5] &
		analog_channel_pin_o) == 3'h0)
		else $error("analog pin also driven");
	led_field_a: assert property (wr_i && addr_i == LED_CTRL_OFFSET
		|=> led_scan_control_o == $past(wdata_i) &&
		led_duty_select_o == $past(wdata_i[7:6]))
		else $error("led control wrong");
	led_commons_a: assert property (led_duty_select_o != 2'h0
		|-> pad_oe_o[3:0] == 4'hF && pad_o[3:0] == led_common_level_i)
		else $error("led commons not driven");
endmodule : port_zero_chk

bind port_zero_pin_control port_zero_chk chk_i (.clk_i(clk_i),
	.rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
	.led_common_level_i(led_common_level_i), .pad_o(pad_o),
	.pad_oe_o(pad_oe_o), .pull_up_o(pull_up_o),
	.schmitt_en_o(schmitt_en_o), .lcd_common_out_o(lcd_common_out_o),
	.analog_channel_pin_o(analog_channel_pin_o),
	.led_duty_select_o(led_duty_select_o),
	.led_scan_control_o(led_scan_control_o));

/* File: testbench/pin_far_side.sv */
// far side model: pads, led scanner and lcd driver levels
// assumes pad controls arrive straight from the block
`timescale 1ns/100ps
module pin_far_side
(
	input wire logic clk_i,
	input wire logic [7:0] pad_out_i,
	input wire logic [7:0] pad_oe_i,
	input wire logic [7:0] pull_up_i,
	output logic [7:0] pad_level_o,
	output logic [3:0] led_level_o,
	output logic [7:0] lcd_level_o
);
	logic [7:0] churn = 8'h5A;
	// floating pads show a moving pattern, never a stale level
	always_ff @(posedge clk_i)
	begin
		churn <= {churn[6:0], churn[7] ^ churn[5]};
	end
	assign pad_level_o = (pad_oe_i & pad_out_i) |
		(~pad_oe_i & (pull_up_i | churn));
	assign led_level_o = churn[3:0];
	assign lcd_level_o = ~churn;
endmodule : pin_far_side

/* File: testbench/testbench.sv */
// bench for the port zero pin control block, random register traffic
// assumes the far-side model and the bound checker
`timescale 1ns/100ps
module testbench
	import port_zero_pkg::*;
;
	logic clk_i, rst_i, wr_i, rd_i;
	logic [7:0] addr_i, wdata_i, rdata_o, pad_i, pad_o, pad_oe_o, v;
	logic [7:0] pull_up_o, schmitt_en_o, lcd_common_out_o, lcd_lvl;
	logic [7:0] led_scan_control_o, pin_in_o;
	logic [3:0] led_lvl;
	logic [2:0] analog_channel_pin_o;
	logic [1:0] led_duty_select_o;
	logic [7:0] sh [5];
	int mismatches, checks_done, k;
	logic [7:0] offs [5] = '{DATA_OFFSET, DRIVE_OFFSET, LCD_BIAS_OFFSET,
		ANALOG_OFFSET, LED_CTRL_OFFSET};
	logic [7:0] rstv [5] = '{DATA_RESET, DRIVE_RESET, LCD_BIAS_RESET,
		{ANALOG_RESET, 5'h00}, LED_CTRL_RESET};
	logic [7:0] rmask [5] = '{8'hFF, 8'hFF, 8'hFF, 8'hE0, 8'hFF};

	port_zero_pin_control port_zero_pin_control_i (.clk_i(clk_i),
		.rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .pad_i(pad_i),
		.led_common_level_i(led_lvl), .lcd_common_level_i(lcd_lvl),
		.pad_o(pad_o), .pad_oe_o(pad_oe_o), .pull_up_o(pull_up_o),
		.schmitt_en_o(schmitt_en_o), .lcd_common_out_o(lcd_common_out_o),
		.analog_channel_pin_o(analog_channel_pin_o),
		.led_duty_select_o(led_duty_select_o),
		.led_scan_control_o(led_scan_control_o), .pin_in_o(pin_in_o));
	pin_far_side pin_far_side_i (.clk_i(clk_i), .pad_out_i(pad_o),
		.pad_oe_i(pad_oe_o), .pull_up_i(pull_up_o), .pad_level_o(pad_i),
		.led_level_o(led_lvl), .lcd_level_o(lcd_lvl));

	// 250 MHz clock
	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	task automatic cmp(input logic [63:0] g, input logic [63:0] e);
		checks_done++;
		if (g !== e)
		begin
			mismatches++;
			$display("mismatch at %0t got %h expected %h", $time, g, e);
		end
	endtask : cmp

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask : rd

	task automatic put(input int r, input logic [7:0] d);
		wr(offs[r], d);
		sh[r] = d;
	endtask : put

	// priority: led scan, lcd bias, analog, then plain port
	function automatic logic [63:0] expect_pins();
		logic [7:0] oe, pu, po, lc, sc, gm;
		logic own;
		for (int i = 0; i < 8; i++)
		begin
			own = sh[4][7:6] != 2'h0 && i < 4;
			gm[i] = !own && !sh[2][i] && !(i > 4 && sh[3][i]);
			oe[i] = own | (gm[i] & sh[1][i]);
			pu[i] = gm[i] & !sh[1][i] & sh[0][i];
			lc[i] = !own & sh[2][i];
			// bias pins carry the lcd driver level
			po[i] = own ? led_lvl[i % 4] :
				lc[i] ? lcd_lvl[i] : oe[i] & sh[0][i];
			sc[i] = gm[i] & !sh[1][i];
		end
		return {oe, pu, po, lc, sc, sh[3][7:5], sh[4][7:6], sh[4]};
	endfunction : expect_pins

	task automatic chk();
		logic [63:0] e;
		#1 e = expect_pins();
		cmp({pad_oe_o, pull_up_o, pad_o & (pad_oe_o | lcd_common_out_o),
			lcd_common_out_o, schmitt_en_o, analog_channel_pin_o,
			led_duty_select_o, led_scan_control_o}, e);
	endtask : chk

	task automatic reset_check(input int n);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (n) @(posedge clk_i);
		rst_i <= 1'b0;
		sh = rstv;
		for (int r = 0; r < 5; r++)
		begin
			rd(offs[r], v);
			cmp(v, rstv[r]);
		end
		chk();
	endtask : reset_check

	task automatic conclude();
		if (mismatches == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude

	initial
	begin
		rst_i = 1'b1;
		{wr_i, rd_i, addr_i, wdata_i} = '0;
		mismatches = 0;
		checks_done = 0;
		void'($urandom(21));
		reset_check(10);
		put(0, 8'hFF);
		repeat (3) @(posedge clk_i);
		#1 cmp(pin_in_o, 8'hFF);
		// touch pins: capacitor low, channel high
		put(1, 8'h18);
		put(0, 8'h08);
		chk();
		put(1, 8'hFF);
		put(3, 8'hE0);
		chk();
		put(2, 8'hFF);
		chk();
		for (int d = 0; d < 4; d++)
		begin
			put(4, {d[1:0], 6'h04});
			chk();
		end
		// unmapped and read-only writes leave the pins alone
		wr(8'h81, 8'hFF);
		wr(PIN_STATE_OFFSET, 8'h00);
		chk();
		// unmapped addresses read back as zero
		rd(8'h81, v);
		cmp(v, 8'h00);
		repeat (80)
		begin
			k = int'($urandom % 5);
			put(k, 8'($urandom));
			chk();
			rd(offs[k], v);
			cmp(v, sh[k] & rmask[k]);
		end
		reset_check(2);
		conclude();
	end
endmodule : testbench
